// ### logic/fwp_pkg.sv
// Package for the flash write-protection block: register map, opcodes, field layout
package fwp_pkg;

    // ------------------------------------------------------------
    // Register byte offsets on the AHB-Lite slave
    // ------------------------------------------------------------
    localparam logic [7:0] FWP_OFS_STATUS = 8'h00;
    localparam logic [7:0] FWP_OFS_CMD    = 8'h04;
    localparam logic [7:0] FWP_OFS_ADDR   = 8'h08;
    localparam logic [7:0] FWP_OFS_RESULT = 8'h0c;
    localparam logic [7:0] FWP_OFS_FUNC   = 8'h10;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int         FWP_ST_BUSY    = 0;
    localparam int         FWP_ST_WEL     = 1;
    localparam int         FWP_ST_BP_LSB  = 2;
    localparam int         FWP_ST_QE      = 6;
    localparam int         FWP_ST_LOCK    = 7;
    localparam int         FWP_FN_BOTTOM  = 1;
    localparam int         FWP_CMD_DATA   = 8;
    localparam logic [7:0] FWP_STATUS_RST = 8'h00;
    localparam int         FWP_ADDR_W     = 25;
    localparam int         FWP_BLK_LSB    = 16;
    localparam logic [9:0] FWP_NUM_BLOCKS = 10'h200;
    localparam logic [3:0] FWP_BP_ALL     = 4'ha;

    // ------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_FUNC_WRITE   = 8'h42;
    localparam logic [7:0] OP_CHIP_ERASE_A = 8'hc7;
    localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic                  valid;
        logic [7:0]            opcode;
        logic [7:0]            data;
        logic [FWP_ADDR_W-1:0] addr;
    } fwp_op_type;

    typedef struct packed {
        logic refused_busy;
        logic refused_lock;
        logic refused_prot;
        logic refused_wel;
        logic accepted;
    } fwp_result_type;

    typedef struct packed {
        logic       lock;
        logic       qe;
        logic [3:0] bp;
    } fwp_nv_type;

endpackage

// ### logic/fwp_core.sv
// Write-protection logic of a serial flash: latch, block protection, status lock, quad pins
//
// The implementer's own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps

module fwp_core
    import fwp_pkg::*;
#(
    parameter logic [7:0] SET_LATCH_OP   = 8'h06,
    parameter logic [7:0] CLEAR_LATCH_OP = 8'h04
) (
    // Clock and reset
    input  wire logic                  mclk_in,
    input  wire logic                  rstn_in,
    // AHB-Lite slave
    input  wire logic                  hsel_in,
    input  wire logic [31:0]           haddr_in,
    input  wire logic [1:0]            htrans_in,
    input  wire logic                  hwrite_in,
    input  wire logic [2:0]            hsize_in,
    input  wire logic [31:0]           hwdata_in,
    input  wire logic                  hready_in,
    output logic      [31:0]           hrdata_out,
    output logic                       hreadyout_out,
    output logic                       hresp_out,
    // Array engine
    output fwp_op_type                 op_out,
    input  wire logic                  op_done_in,
    // Pins
    input  wire logic                  wp_pin_in,
    output logic                       quad_mode_out,
    output logic                       pin_ctrl_func_out
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic                  wel_ff;
    logic                  busy_ff;
    fwp_nv_type            nv_ff;
    logic                  bottom_ff;
    logic [FWP_ADDR_W-1:0] addr_ff;
    logic [15:0]           cmd_ff;
    fwp_result_type        result_ff;
    fwp_op_type            op_ff;
    logic                  dph_wr_ff;
    logic                  dph_rd_ff;
    logic [7:0]            dph_addr_ff;

    // ------------------------------------------------------------
    // Opcode classes
    // ------------------------------------------------------------
    function automatic logic is_array_op(input logic [7:0] op);
        unique case (op)
            8'h02, 8'h12, 8'h32, 8'h38, 8'h34, 8'h3e: is_array_op = 1'b1;
            8'hd7, 8'h20, 8'h21, 8'h52, 8'h5c, 8'hd8, 8'hdc: is_array_op = 1'b1;
            default: is_array_op = 1'b0;
        endcase
    endfunction

    function automatic logic is_gated_op(input logic [7:0] op);
        unique case (op)
            OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: is_gated_op = 1'b1;
            OP_STATUS_WRITE, OP_FUNC_WRITE, 8'h65, 8'h85: is_gated_op = 1'b1;
            8'h64, 8'h62, 8'h15, 8'h18: is_gated_op = 1'b1;
            8'hfd, 8'he3, 8'he4, 8'h2f, 8'ha6, 8'h91, 8'he8: is_gated_op = 1'b1;
            default: is_gated_op = is_array_op(op);
        endcase
    endfunction

    // Region test on the 64 KB block number
    function automatic logic prot_hit(input logic [3:0] bp, input logic bot, input logic [8:0] blk);
        logic [9:0] span;
        span = 10'h001 << (bp - 4'h1);
        if (bp == 4'h0) begin
            prot_hit = 1'b0;
        end else if (bp >= FWP_BP_ALL) begin
            prot_hit = 1'b1;
        end else if (bot) begin
            prot_hit = {1'b0, blk} < span;
        end else begin
            prot_hit = {1'b0, blk} >= (FWP_NUM_BLOCKS - span);
        end
    endfunction

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire        addr_ok  = hsel_in && hready_in && htrans_in[1];
    wire        wr_cmd   = dph_wr_ff && (dph_addr_ff == FWP_OFS_CMD);
    wire        wr_addr  = dph_wr_ff && (dph_addr_ff == FWP_OFS_ADDR);
    wire        cmd_go   = wr_cmd;
    wire [7:0]  cmd_op   = hwdata_in[7:0];
    wire [7:0]  cmd_data = hwdata_in[FWP_CMD_DATA +: 8];
    wire [8:0]  cmd_blk  = addr_ff[FWP_BLK_LSB +: 9];

    // ------------------------------------------------------------
    // Command evaluation
    // ------------------------------------------------------------
    // Protect pin only counts while it is a control pin, not a data line
    wire hw_lock      = nv_ff.lock && !nv_ff.qe && !wp_pin_in;
    wire is_set       = cmd_op == SET_LATCH_OP;
    wire is_clr       = cmd_op == CLEAR_LATCH_OP;
    wire is_chip      = (cmd_op == OP_CHIP_ERASE_A) || (cmd_op == OP_CHIP_ERASE_B);
    wire is_stat_wr   = cmd_op == OP_STATUS_WRITE;
    wire gated        = is_gated_op(cmd_op);
    wire rf_busy      = busy_ff;
    wire rf_wel       = gated && !wel_ff;
    wire rf_prot      = (is_array_op(cmd_op) && prot_hit(nv_ff.bp, bottom_ff, cmd_blk))
                     || (is_chip && (nv_ff.bp != 4'h0));
    wire rf_lock      = is_stat_wr && hw_lock;
    wire refused      = rf_busy || rf_wel || rf_prot || rf_lock;
    wire take         = cmd_go && !refused;
    wire take_write   = take && gated;
    wire done         = op_done_in && busy_ff;

    // Latch flag: instructions, then completion; the two cannot meet since busy refuses
    wire nxt_wel      = (take && is_set)  ? 1'b1 :
                        (take && is_clr)  ? 1'b0 :
                        done              ? 1'b0 :
                        wel_ff;
    wire nxt_busy     = take_write ? 1'b1 : (done ? 1'b0 : busy_ff);

    // Status bits written only by an accepted status write
    wire fwp_nv_type nxt_nv = (take && is_stat_wr) ?
                        fwp_nv_type'({cmd_data[FWP_ST_LOCK], cmd_data[FWP_ST_QE],
                                      cmd_data[FWP_ST_BP_LSB +: 4]}) : nv_ff;
    // One-time bit: only ever ORed in
    wire nxt_bottom   = bottom_ff || (take && (cmd_op == OP_FUNC_WRITE)
                                      && cmd_data[FWP_FN_BOTTOM]);

    wire fwp_result_type nxt_result = cmd_go ?
                        fwp_result_type'({rf_busy, rf_lock && !rf_busy, rf_prot && !rf_busy,
                                          rf_wel && !rf_busy, !refused}) : result_ff;

    // Set-latch and clear-latch commands are handled here; every other accepted command goes to the engine
    wire fwp_op_type nxt_op = fwp_op_type'({take && !is_set && !is_clr, cmd_op, cmd_data, addr_ff});

    // ------------------------------------------------------------
    // Protection state
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            wel_ff    <= 1'b0;
            busy_ff   <= 1'b0;
            nv_ff     <= fwp_nv_type'(FWP_STATUS_RST[7:2]);
            bottom_ff <= 1'b0;
        end else begin
            wel_ff    <= nxt_wel;
            busy_ff   <= nxt_busy;
            nv_ff     <= nxt_nv;
            bottom_ff <= nxt_bottom;
        end
    end

    // Command, address, result and launch registers
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            addr_ff   <= '0;
            cmd_ff    <= 16'h0000;
            result_ff <= '0;
            op_ff     <= '0;
        end else begin
            addr_ff   <= wr_addr ? hwdata_in[FWP_ADDR_W-1:0] : addr_ff;
            cmd_ff    <= cmd_go ? hwdata_in[15:0] : cmd_ff;
            result_ff <= nxt_result;
            op_ff     <= nxt_op;
        end
    end

    // ------------------------------------------------------------
    // AHB-Lite data phase
    // ------------------------------------------------------------
    // Zero wait states: every access completes in its first data cycle
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            dph_wr_ff   <= 1'b0;
            dph_rd_ff   <= 1'b0;
            dph_addr_ff <= 8'h00;
        end else begin
            dph_wr_ff   <= addr_ok && hwrite_in;
            dph_rd_ff   <= addr_ok && !hwrite_in;
            dph_addr_ff <= haddr_in[7:0];
        end
    end

    wire [7:0] status_byte = {nv_ff.lock, nv_ff.qe, nv_ff.bp, wel_ff, busy_ff};
    wire       rd_status   = dph_addr_ff == FWP_OFS_STATUS;
    wire       rd_cmd      = dph_addr_ff == FWP_OFS_CMD;
    wire       rd_addr     = dph_addr_ff == FWP_OFS_ADDR;
    wire       rd_result   = dph_addr_ff == FWP_OFS_RESULT;
    wire       rd_func     = dph_addr_ff == FWP_OFS_FUNC;

    // Read mux over flops; unmapped words read zero
    assign hrdata_out = !dph_rd_ff ? 32'h0000_0000 :
                        rd_status  ? {24'h000000, status_byte} :
                        rd_cmd     ? {16'h0000, cmd_ff} :
                        rd_addr    ? {7'h00, addr_ff} :
                        rd_result  ? {27'h0000000, result_ff} :
                        rd_func    ? {30'h00000000, bottom_ff, 1'b0} :
                        32'h0000_0000;
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign op_out            = op_ff;
    assign quad_mode_out     = nv_ff.qe;
    assign pin_ctrl_func_out = !nv_ff.qe;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_wel_gate_refuse: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        cmd_go && is_gated_op(cmd_op) && !wel_ff |=> !op_ff.valid && !busy_ff && result_ff.refused_wel)
        else $error("gated opcode ran without latch");

    a_set_latch: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        cmd_go && is_set && !busy_ff |=> wel_ff && !op_ff.valid)
        else $error("set latch did not set flag");

    a_clear_latch: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        cmd_go && is_clr && !busy_ff |=> !wel_ff)
        else $error("clear latch did not clear flag");

    a_done_clears_wel: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        op_done_in && busy_ff |=> !wel_ff && !busy_ff)
        else $error("completion left latch or busy set");

    a_prot_region: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        cmd_go && is_array_op(cmd_op) && (nv_ff.bp == 4'h1) && !bottom_ff && (cmd_blk == 9'h1ff)
        |=> !op_ff.valid && result_ff.refused_prot)
        else $error("top block written while protected");

    a_chip_erase_bp: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        cmd_go && is_chip && !busy_ff && (nv_ff.bp != 4'h0) |=> !op_ff.valid ##1 !busy_ff)
        else $error("whole erase ran with protection set");

    a_status_frozen: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        cmd_go && is_stat_wr && hw_lock |=> $stable(nv_ff) && !op_ff.valid)
        else $error("locked status register changed");

    a_stat_wr_keeps_wel: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        take && is_stat_wr |=> wel_ff && busy_ff)
        else $error("status write changed latch flag");

    a_bottom_sticky: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        bottom_ff |=> bottom_ff)
        else $error("bottom select returned to top");

    a_refused_no_busy: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        cmd_go && refused && !busy_ff |=> !busy_ff && $stable(wel_ff) && !op_ff.valid)
        else $error("refused command changed state");

    // ------------------------------------------------------------
    // Class, region and pin checks
    // ------------------------------------------------------------
    // One opcode stands for each class; the decode function is shared, so the rest follow it

    a_wel_gate_accept: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        cmd_go && gated && wel_ff && !busy_ff && !rf_prot && !rf_lock
        |=> op_ff.valid && busy_ff && result_ff.accepted)
        else $error("gated opcode refused with latch set");

    a_ungated_runs: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        cmd_go && !gated && !is_set && !is_clr && !busy_ff
        |=> op_ff.valid && !busy_ff && result_ff.accepted)
        else $error("volatile opcode needed the latch");

    a_clear_no_launch: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        cmd_go && is_clr
        |=> !op_ff.valid)
        else $error("clear latch reached the engine");

    a_busy_holds: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        busy_ff && !op_done_in
        |=> busy_ff)
        else $error("busy dropped before completion");

    a_idle_done_ignored: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        op_done_in && !busy_ff && !cmd_go
        |=> $stable(wel_ff) && !busy_ff)
        else $error("stray completion changed latch");

    a_page_prog_gated: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        cmd_go && (cmd_op == 8'h02) && !wel_ff
        |=> !op_ff.valid && result_ff.refused_wel)
        else $error("page program ran without latch");

    a_erase_gated: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        cmd_go && (cmd_op == 8'hd7) && !wel_ff
        |=> !op_ff.valid && result_ff.refused_wel)
        else $error("sector erase ran without latch");

    a_reg_write_gated: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        cmd_go && (cmd_op == 8'h65) && !wel_ff
        |=> !op_ff.valid && result_ff.refused_wel)
        else $error("register write ran without latch");

    a_info_row_gated: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        cmd_go && (cmd_op == 8'h64) && !wel_ff
        |=> !op_ff.valid && result_ff.refused_wel)
        else $error("info row erase ran without latch");

    a_lock_op_gated: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        cmd_go && (cmd_op == 8'he8) && !wel_ff
        |=> !op_ff.valid && result_ff.refused_wel)
        else $error("password program ran without latch");

    a_top_edge_free: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        cmd_go && is_array_op(cmd_op) && wel_ff && !busy_ff && (nv_ff.bp == 4'h9) && !bottom_ff
        && (cmd_blk == 9'h0ff) |=> op_ff.valid)
        else $error("block below top region refused");

    a_bottom_edge: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        cmd_go && is_array_op(cmd_op) && !busy_ff && (nv_ff.bp == 4'h9) && bottom_ff
        && (cmd_blk == 9'h0ff) |=> !op_ff.valid && result_ff.refused_prot)
        else $error("bottom region block written");

    a_all_blocks: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        cmd_go && is_array_op(cmd_op) && !busy_ff && (nv_ff.bp >= FWP_BP_ALL)
        |=> !op_ff.valid && result_ff.refused_prot)
        else $error("array written with all blocks protected");

    a_status_open: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        cmd_go && is_stat_wr && wel_ff && !busy_ff && !nv_ff.lock
        |=> nv_ff.bp == $past(cmd_data[FWP_ST_BP_LSB +: 4]))
        else $error("unlocked status write lost");

    a_wp_high_opens: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        cmd_go && is_stat_wr && wel_ff && !busy_ff && nv_ff.lock && wp_pin_in
        |=> op_ff.valid && busy_ff)
        else $error("status write refused with pin high");

    a_quad_frees_wp: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        cmd_go && is_stat_wr && wel_ff && !busy_ff && nv_ff.qe
        |=> op_ff.valid && busy_ff)
        else $error("protect pin counted as control in quad mode");

    a_reset_clears_wel: assert property (@(posedge mclk_in)
        !rstn_in
        |=> !wel_ff && !busy_ff)
        else $error("latch or busy set after reset");

    a_busy_refuses: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        cmd_go && busy_ff && !op_done_in
        |=> busy_ff && result_ff.refused_busy && !op_ff.valid)
        else $error("command taken while busy");

endmodule

// ### verif/fwp_engine_model.sv
// Array engine model: answers the latest launched operation after a set delay
`timescale 1ns/1ps
module fwp_engine_model
    import fwp_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk_in,
    input  wire logic       rstn_in,
    // Launch side
    input  wire fwp_op_type op_in,
    input  wire logic [7:0] delay_in,
    // Completion
    output logic            op_done_out
);
    logic [7:0] cnt_ff;
    logic       run_ff;

    // A new launch restarts the count; done pulses for one cycle
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            run_ff      <= 1'b0;
            cnt_ff      <= 8'h00;
            op_done_out <= 1'b0;
        end else begin
            op_done_out <= 1'b0;
            if (op_in.valid) begin
                run_ff <= 1'b1;
                cnt_ff <= delay_in;
            end else if (run_ff && cnt_ff == 8'h00) begin
                run_ff      <= 1'b0;
                op_done_out <= 1'b1;
            end else if (run_ff) begin
                cnt_ff <= cnt_ff - 8'h01;
            end
        end
    end
endmodule

// ### verif/fwp_core_tb.sv
// Self-checking bench for the flash write-protection block
`timescale 1ns/1ps
module fwp_core_tb
    import fwp_pkg::*;
;
    localparam logic [7:0] SET_OP = 8'h06;
    localparam logic [7:0] CLR_OP = 8'h04;
    // Gated flag in bit 8, opcode below; last three rows need no latch
    localparam logic [8:0] ROWS [33] = '{9'h102, 9'h112, 9'h132, 9'h138, 9'h134, 9'h13e, 9'h1d7,
        9'h120, 9'h121, 9'h152, 9'h15c, 9'h1d8, 9'h1dc, 9'h1c7, 9'h160, 9'h101, 9'h142, 9'h165,
        9'h185, 9'h164, 9'h162, 9'h115, 9'h118, 9'h1fd, 9'h1e3, 9'h1e4, 9'h12f, 9'h1a6, 9'h191,
        9'h1e8, 9'h063, 9'h003, 9'h0c0};
    logic        mclk_in   = 1'b0;
    logic        rstn_in   = 1'b0;
    logic        wp_pin    = 1'b0;
    logic        hwrite    = 1'b0;
    logic [1:0]  htrans    = 2'b00;
    logic [31:0] haddr     = 32'h0;
    logic [31:0] hwdata    = 32'h0;
    logic [7:0]  eng_delay = 8'h00;
    logic [31:0] hrdata, rd_q, v;
    logic        hready, hresp, quad_mode, pin_ctrl, op_done;
    fwp_op_type  op;
    int          miscompares = 0;
    int          checked     = 0;
    int          launches    = 0;
    logic [7:0]  last_op     = 8'h00;
    logic [8:0]  last_blk    = 9'h000;

    always #5 mclk_in = ~mclk_in;

    fwp_core #(.SET_LATCH_OP(SET_OP), .CLEAR_LATCH_OP(CLR_OP)) dut (
        .mclk_in(mclk_in), .rstn_in(rstn_in), .hsel_in(1'b1), .haddr_in(haddr), .htrans_in(htrans),
        .hwrite_in(hwrite), .hsize_in(3'b010), .hwdata_in(hwdata), .hready_in(hready),
        .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp), .op_out(op),
        .op_done_in(op_done), .wp_pin_in(wp_pin), .quad_mode_out(quad_mode),
        .pin_ctrl_func_out(pin_ctrl));

    fwp_engine_model eng (.mclk_in(mclk_in), .rstn_in(rstn_in), .op_in(op), .delay_in(eng_delay),
        .op_done_out(op_done));

    // Read data and launches are taken with pre-edge values, so no race with the design
    always @(posedge mclk_in) begin
        rd_q <= hrdata;
        if (op.valid === 1'b1) begin
            launches++;
            last_op = op.opcode;
            last_blk = op.addr[FWP_BLK_LSB +: 9];
        end
    end

    // ------------------------------------------------------------
    // Bus and comparison tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Single AHB-Lite word transfer; waits on hready, never a fixed count
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        haddr  <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge mclk_in); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge mclk_in); while (hready !== 1'b1);
        #1 q = rd_q;
    endtask

    task automatic cmd(input logic [7:0] opc, input logic [7:0] d, input logic [24:0] a, output logic [31:0] r);
        logic [31:0] q;
        bus(1'b1, FWP_OFS_ADDR, {7'h0, a}, q);
        bus(1'b1, FWP_OFS_CMD, {16'h0, d, opc}, q);
        bus(1'b0, FWP_OFS_RESULT, 32'h0, r);
    endtask

    task automatic wait_idle;
        logic [31:0] q;
        int          n;
        q = 32'h1;
        n = 0;
        while (q[0] !== 1'b0 && n < 60) begin
            bus(1'b0, FWP_OFS_STATUS, 32'h0, q);
            n++;
        end
        check({31'h0, q[0]}, 32'h0);
    endtask

    task automatic wr_status(input logic [7:0] d);
        cmd(SET_OP, 8'h00, 25'h0, v);
        cmd(8'h01, d, 25'h0, v);
        check(v, 32'h1);
        wait_idle;
        bus(1'b0, FWP_OFS_STATUS, 32'h0, v);
        check(v, {24'h0, d});
    endtask

    // Refused attempts must leave the latch set and launch nothing
    task automatic try_op(input logic [7:0] opc, input logic [8:0] blk, input logic [31:0] exp);
        cmd(SET_OP, 8'h00, 25'h0, v);
        cmd(opc, 8'h00, {blk, 16'h0}, v);
        check(v, exp);
        bus(1'b0, FWP_OFS_ADDR, 32'h0, v);
        check(v, {7'h0, blk, 16'h0});
        bus(1'b0, FWP_OFS_CMD, 32'h0, v);
        check(v, {24'h0, opc});
        if (exp === 32'h1) begin
            check({23'h0, last_blk}, {23'h0, blk});
            wait_idle;
        end else begin
            bus(1'b0, FWP_OFS_STATUS, 32'h0, v);
            check(v & 32'h3, 32'h2);
            cmd(CLR_OP, 8'h00, 25'h0, v);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Whole run is a few thousand cycles; this is ample headroom
    initial begin
        #500000;
        miscompares++;
        tally_and_finish;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int         l0;
        int         sz;
        int         code;
        logic       g;
        logic [7:0] o;
        repeat (8) @(posedge mclk_in);
        rstn_in <= 1'b1;
        @(posedge mclk_in);
        #1 check({29'h0, quad_mode, pin_ctrl, hresp}, 32'h2);
        bus(1'b0, FWP_OFS_STATUS, 32'h0, v);
        check(v, 32'h0);
        bus(1'b1, 8'h20, 32'hffff_ffff, v);
        bus(1'b0, 8'h20, 32'h0, v);
        check(v, 32'h0);
        $display("test reset done");
        // Delays kept at four or more so the busy phase is still seen by the status read
        for (int i = 0; i < 33; i++) begin
            g = ROWS[i][8];
            o = ROWS[i][7:0];
            l0 = launches;
            eng_delay <= 8'(4 + (i % 3) * 6);
            cmd(o, 8'h00, 25'h0, v);
            check(v, g ? 32'h2 : 32'h1);
            cmd(SET_OP, 8'h00, 25'h0, v);
            bus(1'b0, FWP_OFS_STATUS, 32'h0, v);
            check(v, 32'h2);
            cmd(o, 8'h00, 25'h0, v);
            check(v, 32'h1);
            bus(1'b0, FWP_OFS_STATUS, 32'h0, v);
            check(v, g ? 32'h3 : 32'h2);
            check({24'h0, last_op}, {24'h0, o});
            check(32'(launches - l0), g ? 32'h1 : 32'h2);
            if (g) wait_idle;
            else cmd(CLR_OP, 8'h00, 25'h0, v);
            bus(1'b0, FWP_OFS_STATUS, 32'h0, v);
            check(v, 32'h0);
        end
        $display("test opcode rows done");
        eng_delay <= 8'h00;
        for (int s = 0; s < 2; s++) begin
            if (s == 1) begin
                cmd(SET_OP, 8'h00, 25'h0, v);
                cmd(8'h42, 8'h02, 25'h0, v);
                wait_idle;
                bus(1'b0, FWP_OFS_FUNC, 32'h0, v);
                check(v, 32'h2);
            end
            for (int n = 1; n < 12; n++) begin
                code = (n == 11) ? 15 : n;
                wr_status(8'(code << 2));
                if (code < 10) begin
                    sz = 1 << (code - 1);
                    try_op(8'hd8, 9'(s ? sz - 1 : 512 - sz), 32'h4);
                    try_op(8'h20, 9'(s ? sz : 511 - sz), 32'h1);
                end else begin
                    try_op(8'h02, 9'(s ? 511 : 0), 32'h4);
                end
                if (n == 1) try_op(8'hc7, 9'h0, 32'h4);
            end
            wr_status(8'h00);
        end
        cmd(SET_OP, 8'h00, 25'h0, v);
        cmd(8'h42, 8'h00, 25'h0, v);
        wait_idle;
        bus(1'b0, FWP_OFS_FUNC, 32'h0, v);
        check(v, 32'h2);
        $display("test protection done");
        wr_status(8'h80);
        cmd(SET_OP, 8'h00, 25'h0, v);
        cmd(8'h01, 8'h04, 25'h0, v);
        check(v, 32'h8);
        bus(1'b0, FWP_OFS_STATUS, 32'h0, v);
        check(v, 32'h82);
        cmd(CLR_OP, 8'h00, 25'h0, v);
        wp_pin <= 1'b1;
        wr_status(8'h00);
        wr_status(8'hc0);
        check({30'h0, quad_mode, pin_ctrl}, 32'h2);
        wp_pin <= 1'b0;
        wr_status(8'h00);
        check({30'h0, quad_mode, pin_ctrl}, 32'h1);
        $display("test lock and quad done");
        eng_delay <= 8'd40;
        cmd(SET_OP, 8'h00, 25'h0, v);
        cmd(8'h20, 8'h00, 25'h0, v);
        check(v, 32'h1);
        cmd(8'h03, 8'h00, 25'h0, v);
        check(v, 32'h10);
        wait_idle;
        cmd(SET_OP, 8'h00, 25'h0, v);
        rstn_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
        rstn_in <= 1'b1;
        @(posedge mclk_in);
        bus(1'b0, FWP_OFS_STATUS, 32'h0, v);
        check(v, 32'h0);
        $display("test busy and second reset done");
        tally_and_finish;
    end
endmodule
